// [verification/testbench.sv]
// Self-checking bench of the flag and edge-select timer
`timescale 1ns/1ps
module testbench
	import timer_flag_pkg::*;
;
	logic         mclk = 1'b0;
	logic         arst_n = 1'b0;
	avmm_req_t    req = '0;
	avmm_rsp_t    rsp;
	logic [3:0]   evt = 4'h0, en = 4'h0, dis = 4'h0, nz = 4'h0, lag = 4'h0, mirq;
	xfer_status_t xs;
	logic [15:0]  cnt;
	logic         tk, irq;
	logic [31:0]  q;
	int           err_total = 0, n_tests = 0, cyc = 0;
	timer_flag_top dut_u (.mclk(mclk), .arst_n(arst_n), .bus_req(req), .bus_rsp(rsp),
		.flag_set_evt(evt), .xfer(xs), .match_irq(mirq), .count_value(cnt),
		.count_tick(tk), .irq(irq));
	xfer_ctrl_model xc_u (.mclk(mclk), .arst_n(arst_n), .irq_req(mirq), .enable(en),
		.dis_cfg(dis), .nz_cfg(nz), .lag(lag), .xfer(xs));
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			results();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{!w, w, a, d, 4'hf};
		do @(posedge mclk); while (rsp.waitrequest !== 1'b0);
		q = rsp.readdata;
		req <= '0;
	endtask : acc
	task automatic tick(output int t);
		do @(posedge mclk); while (tk !== 1'b1);
		t = cyc;
	endtask : tick
	task automatic pulse(input logic [3:0] m);
		@(posedge mclk);
		evt <= m;
		@(posedge mclk);
		evt <= 4'h0;
		@(posedge mclk);
	endtask : pulse
	task automatic t_reg;
		logic [4:0]  o [6] = '{OFS_CTRL, OFS_FLAG, OFS_COUNT, OFS_STAT, OFS_MASK, 5'h14};
		logic [31:0] e [6] = '{CTRL_RESET, FLAG_RESET, COUNT_RESET, STAT_RESET, MASK_RESET,
			DATA_ZERO};
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, o[i], 32'h0);
			chk("reset value", e[i], q);
		end
		acc(1'b1, 5'h14, 32'hffff_ffff);
		acc(1'b0, 5'h14, 32'h0);
		chk("unmapped", DATA_ZERO, q);
		acc(1'b1, OFS_COUNT, 32'h0000_a5c3);
		acc(1'b0, OFS_COUNT, 32'h0);
		chk("count rw", 32'h0000_a5c3, q);
		$display("end t_reg");
	endtask : t_reg
	task automatic t_div1;
		logic [15:0] c0;
		for (int e = 0; e < 3; e++) begin
			acc(1'b1, OFS_CTRL, 32'(e) << 3);
			acc(1'b1, OFS_CTRL, 32'h20 | 32'(e) << 3);
			@(posedge mclk);
			c0 = cnt;
			repeat (10) @(posedge mclk);
			chk("div1 count", c0 + 16'h000a, cnt);
		end
		$display("end t_div1");
	endtask : t_div1
	// Run is dropped around each change, since a live prescale change may tick once
	task automatic t_edge;
		int t0, t1, per;
		int ph [2];
		for (int p = 1; p < 4; p++) begin
			per = 4 ** p;
			for (int e = 0; e < 3; e++) begin
				acc(1'b1, OFS_CTRL, 32'(p) | 32'(e) << 3);
				acc(1'b1, OFS_CTRL, 32'h20 | 32'(p) | 32'(e) << 3);
				tick(t0);
				tick(t0);
				tick(t1);
				chk("tick gap", (e == 2) ? per / 2 : per, t1 - t0);
				if (e < 2)
					ph[e] = t1 % per;
			end
			chk("edge phase", per / 2, (ph[1] - ph[0] + per) % per);
		end
		$display("end t_edge");
	endtask : t_edge
	task automatic t_xclr;
		nz <= 4'hf;
		for (int c = 0; c < 4; c++) begin
			lag <= 4'(c * 3);
			dis <= 4'hf;
			en  <= 4'h1 << c;
			pulse(4'h1 << c);
			repeat (14) @(posedge mclk);
			chk("kept dis", 32'h1, mirq[c]);
			dis <= 4'h0;
			nz  <= 4'h0;
			repeat (14) @(posedge mclk);
			chk("kept nz", 32'h1, mirq[c]);
			nz <= 4'hf;
			repeat (14) @(posedge mclk);
			chk("xfer clear", 32'h0, mirq[c]);
		end
		en <= 4'h0;
		$display("end t_xclr");
	endtask : t_xclr
	task automatic t_sw;
		pulse(4'hf);
		acc(1'b1, OFS_FLAG, 32'h0);
		acc(1'b0, OFS_FLAG, 32'h0);
		chk("unarmed write", 32'hf, q);
		acc(1'b1, OFS_FLAG, 32'ha);
		acc(1'b0, OFS_FLAG, 32'h0);
		chk("clear a c", 32'ha, q);
		acc(1'b1, OFS_FLAG, 32'h0);
		acc(1'b0, OFS_FLAG, 32'h0);
		chk("clear b d", 32'h0, q);
		$display("end t_sw");
	endtask : t_sw
	// The set event is timed to land on the accept edge of an armed zero write
	task automatic t_coincide;
		pulse(4'h1);
		acc(1'b0, OFS_FLAG, 32'h0);
		chk("armed read", 32'h1, q);
		fork
			acc(1'b1, OFS_FLAG, 32'h0);
			begin
				repeat (2) @(posedge mclk);
				evt <= 4'h1;
				@(posedge mclk);
				evt <= 4'h0;
			end
		join
		acc(1'b0, OFS_FLAG, 32'h0);
		chk("set beats clear", 32'h1, q);
		$display("end t_coincide");
	endtask : t_coincide
	task automatic t_irq;
		acc(1'b1, OFS_MASK, 32'h2);
		acc(1'b0, OFS_STAT, 32'h0);
		pulse(4'h1);
		chk("irq masked", 32'h0, irq);
		pulse(4'h2);
		chk("irq raised", 32'h1, irq);
		acc(1'b0, OFS_STAT, 32'h0);
		chk("stat", 32'h3, q);
		@(posedge mclk);
		chk("irq cleared", 32'h0, irq);
		acc(1'b0, OFS_MASK, 32'h0);
		chk("mask", 32'h2, q);
		$display("end t_irq");
	endtask : t_irq
	task automatic results;
		$display("mismatches %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		t_reg();
		t_div1();
		t_edge();
		t_xclr();
		t_sw();
		t_coincide();
		t_irq();
		results();
	end
endmodule : testbench

// [verification/timer_flag_assertions.sv]
// Port checks of the flag and edge-select timer
`timescale 1ns/1ps
module timer_flag_assertions
	import timer_flag_pkg::*;
#(
	parameter int NUM_CH = CHANNELS,
	parameter int CNT_W  = COUNT_W
) (
	input wire logic              mclk,
	input wire logic              arst_n,
	input wire avmm_req_t         bus_req,
	input wire avmm_rsp_t         bus_rsp,
	input wire logic [NUM_CH-1:0] flag_set_evt,
	input wire xfer_status_t      xfer,
	input wire logic [NUM_CH-1:0] match_irq,
	input wire logic [CNT_W-1:0]  count_value,
	input wire logic              count_tick,
	input wire logic              irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [7:0] ctl;
	logic [3:0] armed;
	wire       acc  = (bus_req.read || bus_req.write) && !bus_rsp.waitrequest;
	wire       fsel = bus_req.address[4:2] == OFS_FLAG[4:2];
	wire       wfl  = acc && bus_req.write && fsel && bus_req.byteenable[0];
	wire [3:0] xclr = xfer.activated & ~xfer.disable_sel & xfer.count_nonzero;
	wire [3:0] xc   = xclr & ~flag_set_evt;
	wire [3:0] wz   = armed & ~bus_req.writedata[3:0] & ~flag_set_evt;
	wire       d4   = ctl[5] && ctl[1:0] == PSC_DIV4 && !ctl[4];
	// Shadow of control and armed bits, kept from accepted bus cycles
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl   <= CTRL_RESET;
			armed <= 4'h0;
		end else begin
			if (acc && bus_req.write && bus_req.address[4:2] == 3'h0 && bus_req.byteenable[0])
				ctl <= bus_req.writedata[7:0];
			armed <= wfl ? 4'h0 : (acc && bus_req.read && fsel) ? bus_rsp.readdata[3:0]
				: armed & ~xclr;
		end
	end
	AST_SET: assert property (|flag_set_evt |=> (match_irq & $past(flag_set_evt)) == $past(flag_set_evt))
		else $error("flag not set by event");
	AST_XCLR: assert property (|xc |=> (match_irq & $past(xc)) == 4'h0)
		else $error("flag kept after transfer activation");
	AST_NOSET: assert property (!(|flag_set_evt) |=> (match_irq & ~$past(match_irq)) == 4'h0)
		else $error("flag set without event");
	AST_HOLD: assert property (!(|xclr) && !wfl && !(|flag_set_evt) |=> $stable(match_irq))
		else $error("flag changed without cause");
	AST_SWCLR: assert property (wfl |=> (match_irq & $past(wz)) == 4'h0)
		else $error("armed flag kept after zero write");
	AST_NOARM: assert property (wfl && armed == 4'h0 && !(|xclr) |=> match_irq == ($past(match_irq) | $past(flag_set_evt)))
		else $error("unarmed write changed flags");
	AST_DIV1: assert property (ctl[5] && ctl[1:0] == PSC_DIV1 |-> count_tick)
		else $error("undivided clock missed a count");
	AST_DIV4: assert property (count_tick && d4 |=> (!count_tick || !d4) [*3])
		else $error("divide by four ticked early");
	COV_XCLR: cover property (|xclr);
	COV_SW: cover property (wfl && armed != 4'h0);
	COV_D4: cover property (count_tick && d4);
endmodule : timer_flag_assertions
bind timer_flag_top timer_flag_assertions #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) chk_u (
	.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .bus_rsp(bus_rsp),
	.flag_set_evt(flag_set_evt), .xfer(xfer), .match_irq(match_irq),
	.count_value(count_value), .count_tick(count_tick), .irq(irq));

// [verification/xfer_ctrl_model.sv]
// Transfer controller model answering flag interrupts after a set lag
`timescale 1ns/1ps
module xfer_ctrl_model
	import timer_flag_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire logic [CHANNELS-1:0] irq_req,
	input  wire logic [CHANNELS-1:0] enable,
	input  wire logic [CHANNELS-1:0] dis_cfg,
	input  wire logic [CHANNELS-1:0] nz_cfg,
	input  wire logic [3:0]          lag,
	output xfer_status_t             xfer
);
	logic [3:0]          lag_cnt;
	logic [CHANNELS-1:0] act;
	wire  [CHANNELS-1:0] pend = irq_req & enable;
	assign xfer = {act, dis_cfg, nz_cfg};
	// Retries while the request stands, so an ignored activation comes back
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lag_cnt <= 4'h0;
			act     <= 4'h0;
		end else begin
			act     <= (lag_cnt == lag) ? pend : 4'h0;
			lag_cnt <= (|pend && lag_cnt != lag) ? lag_cnt + 4'h1 : 4'h0;
		end
	end
endmodule : xfer_ctrl_model

// [verilog/count_clock_select.sv]
// Prescaler and count-edge selection producing the counter advance pulse
`timescale 1ns/1ps
module count_clock_select
	import timer_flag_pkg::*;
#(
	parameter int PRESC_W = DIV_W
) (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic [1:0] psc_sel,
	input  wire logic [1:0] edge_sel,
	output logic            count_tick
);

	generate
		if (PRESC_W < DIV_W) begin : g_bad_width
			$error("count_clock_select: prescaler too narrow for divide by 64");
		end
	endgenerate

	logic [PRESC_W-1:0] presc;
	logic               presc_prev;
	wire                presc_level;
	wire                rise;
	wire                fall;
	wire                edge_tick;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			presc      <= '0;
			presc_prev <= 1'b0;
		end else begin
			presc      <= presc + 1'b1;
			presc_prev <= presc_level;
		end
	end

	// Square wave of the chosen division; bit n toggles every 2^n cycles
	assign presc_level = (psc_sel == PSC_DIV4)  ? presc[1] :
	                     (psc_sel == PSC_DIV16) ? presc[3] : presc[5];
	assign rise        = presc_level & ~presc_prev;
	assign fall        = ~presc_level & presc_prev;
	assign edge_tick   = (edge_sel == EDGE_RISE) ? rise :
	                     (edge_sel == EDGE_FALL) ? fall : (rise | fall);

	// Undivided clock: every rising edge of the system clock counts
	assign count_tick  = run & ((psc_sel == PSC_DIV1) ? 1'b1 : edge_tick);

endmodule : count_clock_select

// [verilog/match_flag_cell.sv]
// One capture/compare flag with its transfer-controller and read-then-write clearing
`timescale 1ns/1ps
module match_flag_cell (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic set_evt,
	input  wire logic xfer_activated,
	input  wire logic xfer_disable_sel,
	input  wire logic xfer_count_nonzero,
	input  wire logic read_as_one,
	input  wire logic write_any,
	input  wire logic write_zero,
	output logic      flag,
	output logic      irq
);

	logic armed;
	wire  xfer_clear;
	wire  sw_clear;
	wire  next_flag;
	wire  next_armed;

	assign xfer_clear = xfer_activated & ~xfer_disable_sel & xfer_count_nonzero;
	// A zero write counts only after the flag was seen as one
	assign sw_clear   = write_zero & armed;
	// Set beats any clear in the same cycle; writing one does nothing
	assign next_flag  = set_evt | (flag & ~(xfer_clear | sw_clear));
	assign next_armed = read_as_one | (armed & ~write_any & ~xfer_clear);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flag  <= 1'b0;
			armed <= 1'b0;
		end else begin
			flag  <= next_flag;
			armed <= next_armed;
		end
	end

	assign irq = flag;

endmodule : match_flag_cell

// [verilog/timer_flag_pkg.sv]
// Shared constants, field layouts and carrier types of the flag and edge-select timer block
package timer_flag_pkg;

	localparam int ADDR_W   = 5;
	localparam int DATA_W   = 32;
	localparam int BE_W     = 4;
	localparam int CHANNELS = 4;
	localparam int COUNT_W  = 16;
	localparam int CTRL_W   = 8;
	localparam int DIV_W    = 6;

	// Byte offsets of the word registers
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAG  = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_MASK  = 5'h10;

	// Control register fields
	localparam int CTRL_PSC_LSB  = 0;
	localparam int CTRL_EDGE_LSB = 3;
	localparam int CTRL_RUN_BIT  = 5;
	localparam logic [CTRL_W-1:0] CTRL_USED = 8'h3b;

	// Prescaler and edge encodings
	localparam logic [1:0] PSC_DIV1  = 2'h0;
	localparam logic [1:0] PSC_DIV4  = 2'h1;
	localparam logic [1:0] PSC_DIV16 = 2'h2;
	localparam logic [1:0] PSC_DIV64 = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// Reset values
	localparam logic [CTRL_W-1:0]   CTRL_RESET  = 8'h00;
	localparam logic [CHANNELS-1:0] FLAG_RESET  = 4'h0;
	localparam logic [CHANNELS-1:0] STAT_RESET  = 4'h0;
	localparam logic [CHANNELS-1:0] MASK_RESET  = 4'h0;
	localparam logic [COUNT_W-1:0]  COUNT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0]   DATA_ZERO   = 32'h0000_0000;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0]   byteenable;
	} avmm_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} avmm_rsp_t;

	typedef struct packed {
		logic [CHANNELS-1:0] activated;
		logic [CHANNELS-1:0] disable_sel;
		logic [CHANNELS-1:0] count_nonzero;
	} xfer_status_t;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;

endpackage : timer_flag_pkg

// [verilog/timer_flag_top.sv]
// Timer count-edge selection, capture/compare flags and Avalon-MM register slave
// Overview of operation
// - Edge select honoured for divide-by-four or slower
// - Undivided clock counts every rising edge
// - Transfer activation by interrupt clears flag D
// - Zero write after reading one clears D
// - Transfer activation by interrupt clears flag C
// - Zero write after reading one clears C
// - Transfer activation by interrupt clears flag B
// - Zero write after reading one clears B
// - Flag A clears under both same conditions
`timescale 1ns/1ps
module timer_flag_top
	import timer_flag_pkg::*;
#(
	parameter int NUM_CH = CHANNELS,
	parameter int CNT_W  = COUNT_W
) (
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire avmm_req_t           bus_req,
	output avmm_rsp_t                bus_rsp,
	input  wire logic [NUM_CH-1:0]   flag_set_evt,
	input  wire xfer_status_t        xfer,
	output logic [NUM_CH-1:0]        match_irq,
	output logic [CNT_W-1:0]         count_value,
	output logic                     count_tick,
	output logic                     irq
);

	generate
		if (NUM_CH != CHANNELS || CNT_W != COUNT_W) begin : g_bad_param
			$error("timer_flag_top: channel count and counter width are fixed");
		end
	endgenerate

	function automatic logic hit(input logic [ADDR_W-1:0] addr,
	                             input logic [ADDR_W-1:0] ofs);
		hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction : hit

	bus_state_t          bus_state;
	bus_state_t          next_bus_state;
	logic [DATA_W-1:0]   rdata;
	logic [CTRL_W-1:0]   timer_control_reg;
	logic [NUM_CH-1:0]   irq_stat;
	logic [NUM_CH-1:0]   irq_mask;
	logic [CNT_W-1:0]    count;
	logic [NUM_CH-1:0]   match_flag;

	wire                 req;
	wire                 first_cycle;
	wire                 accept;
	wire                 acc_read;
	wire                 acc_write;
	wire                 sel_ctrl;
	wire                 sel_flag;
	wire                 sel_count;
	wire                 sel_stat;
	wire                 sel_mask;
	wire                 lane0;
	wire                 lane1;
	wire [DATA_W-1:0]    next_rdata;
	wire [CTRL_W-1:0]    next_ctrl;
	wire [NUM_CH-1:0]    next_mask;
	wire [NUM_CH-1:0]    stat_rd_clear;
	wire [NUM_CH-1:0]    next_stat;
	wire [NUM_CH-1:0]    flag_read_one;
	wire                 flag_write;
	wire [NUM_CH-1:0]    flag_write_zero;
	wire [CNT_W-1:0]     count_wr_value;
	wire [CNT_W-1:0]     next_count;
	wire [1:0]           psc_sel;
	wire [1:0]           edge_sel;
	wire                 run;
	wire                 tick;

	// Bus handshake: every access waits one cycle, then completes
	assign req         = bus_req.read | bus_req.write;
	assign first_cycle = req & (bus_state == BUS_IDLE);
	assign accept      = req & (bus_state == BUS_ANSWER);
	assign acc_read    = accept & bus_req.read;
	assign acc_write   = accept & bus_req.write;

	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (req) begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Address decode
	assign sel_ctrl  = hit(bus_req.address, OFS_CTRL);
	assign sel_flag  = hit(bus_req.address, OFS_FLAG);
	assign sel_count = hit(bus_req.address, OFS_COUNT);
	assign sel_stat  = hit(bus_req.address, OFS_STAT);
	assign sel_mask  = hit(bus_req.address, OFS_MASK);
	assign lane0     = bus_req.byteenable[0];
	assign lane1     = bus_req.byteenable[1];

	// Read data is captured in the wait cycle and held for the answer cycle,
	// so read side effects below act only on the bits the master really sees
	assign next_rdata =
		sel_ctrl  ? {{(DATA_W-CTRL_W){1'b0}}, timer_control_reg & CTRL_USED} :
		sel_flag  ? {{(DATA_W-NUM_CH){1'b0}}, match_flag} :
		sel_count ? {{(DATA_W-CNT_W){1'b0}}, count} :
		sel_stat  ? {{(DATA_W-NUM_CH){1'b0}}, irq_stat} :
		sel_mask  ? {{(DATA_W-NUM_CH){1'b0}}, irq_mask} : DATA_ZERO;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= DATA_ZERO;
		end else if (first_cycle && bus_req.read) begin
			rdata <= next_rdata;
		end
	end

	assign bus_rsp.readdata    = rdata;
	assign bus_rsp.waitrequest = req & ~accept;

	// Control register
	assign next_ctrl = (acc_write && sel_ctrl && lane0) ?
	                   (bus_req.writedata[CTRL_W-1:0] & CTRL_USED) : timer_control_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			timer_control_reg <= CTRL_RESET;
		end else begin
			timer_control_reg <= next_ctrl;
		end
	end

	assign psc_sel  = timer_control_reg[CTRL_PSC_LSB +: 2];
	assign edge_sel = timer_control_reg[CTRL_EDGE_LSB +: 2];
	assign run      = timer_control_reg[CTRL_RUN_BIT];

	count_clock_select #(
		.PRESC_W (DIV_W)
	) u_clock_select (
		.mclk       (mclk),
		.arst_n     (arst_n),
		.run        (run),
		.psc_sel    (psc_sel),
		.edge_sel   (edge_sel),
		.count_tick (tick)
	);

	// Counter: a software write to a lane overrides the tick in that cycle
	assign count_wr_value = {lane1 ? bus_req.writedata[15:8] : count[15:8],
	                         lane0 ? bus_req.writedata[7:0]  : count[7:0]};
	assign next_count     = (acc_write && sel_count) ? count_wr_value :
	                        tick ? count + 1'b1 : count;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count <= COUNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	assign count_value = count;
	assign count_tick  = tick;

	// Flag register access: a read arms the flags returned as one,
	// a write with lane 0 offers a zero-clear to each bit written as zero
	assign flag_read_one   = (acc_read && sel_flag) ? rdata[NUM_CH-1:0] : '0;
	assign flag_write      = acc_write & sel_flag & lane0;
	assign flag_write_zero = flag_write ? ~bus_req.writedata[NUM_CH-1:0] : '0;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_flag
			match_flag_cell u_cell (
				.mclk               (mclk),
				.arst_n             (arst_n),
				.set_evt            (flag_set_evt[ch]),
				.xfer_activated     (xfer.activated[ch]),
				.xfer_disable_sel   (xfer.disable_sel[ch]),
				.xfer_count_nonzero (xfer.count_nonzero[ch]),
				.read_as_one        (flag_read_one[ch]),
				.write_any          (flag_write),
				.write_zero         (flag_write_zero[ch]),
				.flag               (match_flag[ch]),
				.irq                (match_irq[ch])
			);
		end
	endgenerate

	// Interrupt status: sticky on each flag-setting event, cleared by reading it;
	// only the bits returned by that read are cleared, and a new event wins
	assign stat_rd_clear = (acc_read && sel_stat) ? rdata[NUM_CH-1:0] : '0;
	assign next_stat     = (irq_stat & ~stat_rd_clear) | flag_set_evt;
	assign next_mask     = (acc_write && sel_mask && lane0) ?
	                       bus_req.writedata[NUM_CH-1:0] : irq_mask;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat <= STAT_RESET;
			irq_mask <= MASK_RESET;
		end else begin
			irq_stat <= next_stat;
			irq_mask <= next_mask;
		end
	end

	assign irq = |(irq_stat & irq_mask);

endmodule : timer_flag_top
